// [hw/reset_debug_pin_config.sv]
// Reset, reset-out and debug pin function control with port pin defaults
//
// Contract
// [R1] Shared pin is input until reset-pin enabled
// [R2] Low external reset pin resets device
// [R3] Reset pin input only, pull-up automatic
// [R4] Reset-out enable selects output function until power-on
// [R5] Reset-out pin low during reset, else high
// [R6] Reset-out pin output only, independent enable
// [R7] Debug pin samples mode during power-on/forced reset
// [R8] Debug pin enable set by every reset
// [R9] Mode pin low at reset forces background mode
// [R10] Debug bit time is sixteen clock cycles
// [R11] Debug protocol drives brief high speed-up pulse
// [R12] Outputs pick drive and slew; inputs pull-up
// [R13] Port pins reset to inputs, no pull-up
// [R14] Port data read follows direction bit
// [R15] Internal clock selected after reset
// [R16] Oscillator may keep running in stop modes
// [R17] Reset pin enables cleared only by power-on
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module reset_debug_pin_config
#(
    parameter int PORT_W = 8
) (
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic POR_N,
    input wire logic FORCE_RST,
    input wire logic [pin_cfg_pkg::ADDR_W-1:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic RSTPIN_I,
    output logic RSTPIN_PULL,
    output logic SYS_RST_REQ,
    input wire logic RSTOPIN_I,
    output pin_cfg_pkg::pad_s RESET_OUT_PIN_PAD,
    input wire logic BKGD_I,
    output pin_cfg_pkg::pad_s BKGD_PAD,
    output logic BACKGROUND_MODE,
    input wire logic [PORT_W-1:0] PORT_I,
    input wire logic [PORT_W-1:0] PERIPH_SEL,
    input wire logic [PORT_W-1:0] PERIPH_OE,
    input wire logic [PORT_W-1:0] PERIPH_O,
    output logic [PORT_W-1:0] PORT_O,
    output logic [PORT_W-1:0] PORT_OE,
    output logic [PORT_W-1:0] PORT_PULL,
    output logic [PORT_W-1:0] PORT_DRIVE,
    output logic [PORT_W-1:0] PORT_SLEW,
    output logic CLK_SEL_EXT,
    output logic OSC_STOP_RUN
);
    import pin_cfg_pkg::*;

    logic rst_pin_en_r;
    logic reset_out_pin_en_r;
    logic dbg_en_r;
    logic [PORT_W-1:0] dir_r, out_r, pull_r, drive_r, slew_r;
    logic [4:0] pinctl_r;
    logic [1:0] clkctl_r;
    logic ms_low_r;
    bdc_st_e bdc_st_r, bdc_st_nxt;
    logic [3:0] cnt_r;
    logic [3:0] low_len_r;
    logic bdc_busy;
    logic wr_en;
    logic [PORT_W-1:0] port_rd;
    logic [31:0] rd_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the access completes
    assign wr_en = WRITE && !WAITREQUEST;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            WAITREQUEST <= 1'b1;
        end else if ((READ || WRITE) && WAITREQUEST) begin
            WAITREQUEST <= 1'b0;
        end else begin
            WAITREQUEST <= 1'b1;
        end
    end

    // Data read follows direction, not the peripheral's enable
    assign port_rd = (dir_r & out_r) | (~dir_r & PORT_I); // R14
    assign bdc_busy = (bdc_st_r != ST_IDLE);

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_nxt = RD_ZERO;
        unique case (ADDRESS)
            OFS_SYSOPT: begin
                rd_nxt[B_RSTPIN] = rst_pin_en_r;
                rd_nxt[B_RSTOUT] = reset_out_pin_en_r;
                rd_nxt[B_DBGEN] = dbg_en_r;
            end
            OFS_DIR: rd_nxt[PORT_W-1:0] = dir_r;
            OFS_OUT: rd_nxt[PORT_W-1:0] = out_r;
            OFS_PULL: rd_nxt[PORT_W-1:0] = pull_r;
            OFS_DRIVE: rd_nxt[PORT_W-1:0] = drive_r;
            OFS_SLEW: rd_nxt[PORT_W-1:0] = slew_r;
            OFS_DATA: rd_nxt[PORT_W-1:0] = port_rd;
            OFS_PINCTL: begin
                rd_nxt[4:0] = pinctl_r;
                rd_nxt[B_PA5_LVL] = RSTPIN_I; // R1
                rd_nxt[B_BK_LVL] = BKGD_I;
                rd_nxt[B_MS_LOW] = ms_low_r;
                rd_nxt[B_BUSY] = bdc_busy;
            end
            OFS_CLKCTL: rd_nxt[1:0] = clkctl_r;
            OFS_BDCTX: rd_nxt[0] = bdc_busy;
            default: rd_nxt = RD_ZERO;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            READDATA <= RD_ZERO;
        end else if (READ && WAITREQUEST) begin
            READDATA <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Set-only enables: any write of a one sets them; only power-on clears them
    always_ff @(posedge CLOCK) begin
        if (!POR_N) begin
            rst_pin_en_r <= 1'b0; // R1
            reset_out_pin_en_r <= 1'b0; // R4
        end else if (wr_en && ADDRESS == OFS_SYSOPT) begin
            rst_pin_en_r <= rst_pin_en_r | WRITEDATA[B_RSTPIN]; // R17
            reset_out_pin_en_r <= reset_out_pin_en_r | WRITEDATA[B_RSTOUT]; // R17
        end
    end

    // Debug pin enable comes back on with any reset
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dbg_en_r <= 1'b1; // R8
        end else if (wr_en && ADDRESS == OFS_SYSOPT) begin
            dbg_en_r <= WRITEDATA[B_DBGEN];
        end
    end

    // Port configuration: all inputs, no pull-up after reset
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dir_r <= '0; // R13
            out_r <= '0;
            pull_r <= '0; // R13
            drive_r <= '0;
            slew_r <= '0;
        end else if (wr_en) begin
            if (ADDRESS == OFS_DIR) dir_r <= WRITEDATA[PORT_W-1:0];
            if (ADDRESS == OFS_OUT) out_r <= WRITEDATA[PORT_W-1:0];
            if (ADDRESS == OFS_PULL) pull_r <= WRITEDATA[PORT_W-1:0]; // R12
            if (ADDRESS == OFS_DRIVE) drive_r <= WRITEDATA[PORT_W-1:0]; // R12
            if (ADDRESS == OFS_SLEW) slew_r <= WRITEDATA[PORT_W-1:0]; // R12
        end
    end

    // Dedicated pin general-purpose controls and clock controls
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pinctl_r <= '0;
            clkctl_r <= '0; // R15
        end else if (wr_en) begin
            if (ADDRESS == OFS_PINCTL) pinctl_r <= WRITEDATA[4:0];
            if (ADDRESS == OFS_CLKCTL) clkctl_r <= WRITEDATA[1:0]; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port pads: peripheral owns the buffer enable when selected
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            PORT_O <= '0;
            PORT_OE <= '0; // R13
            PORT_PULL <= '0;
            PORT_DRIVE <= '0;
            PORT_SLEW <= '0;
        end else begin
            PORT_O <= (PERIPH_SEL & PERIPH_O) | (~PERIPH_SEL & out_r);
            PORT_OE <= (PERIPH_SEL & PERIPH_OE) | (~PERIPH_SEL & dir_r);
            PORT_PULL <= pull_r & ~((PERIPH_SEL & PERIPH_OE) | (~PERIPH_SEL & dir_r)); // R12
            PORT_DRIVE <= drive_r; // R12
            PORT_SLEW <= slew_r; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External reset pin: input only, pull-up forced on when enabled
    always_ff @(posedge CLOCK) begin
        if (!POR_N) begin
            RSTPIN_PULL <= 1'b0;
            SYS_RST_REQ <= 1'b0;
        end else begin
            RSTPIN_PULL <= rst_pin_en_r | pinctl_r[B_PA5_PULL]; // R3
            SYS_RST_REQ <= rst_pin_en_r && !RSTPIN_I; // R2
        end
    end

    // Reset-out pad mirrors the internal reset; never an input then
    always_ff @(posedge CLOCK) begin
        if (!POR_N) begin
            RESET_OUT_PIN_PAD <= '0;
        end else if (reset_out_pin_en_r) begin
            RESET_OUT_PIN_PAD.o <= RST_N; // R5
            RESET_OUT_PIN_PAD.oe <= 1'b1; // R6
            RESET_OUT_PIN_PAD.pull <= 1'b0;
        end else begin
            RESET_OUT_PIN_PAD.o <= pinctl_r[B_PC4_OUT]; // R4
            RESET_OUT_PIN_PAD.oe <= pinctl_r[B_PC4_DIR];
            RESET_OUT_PIN_PAD.pull <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode sample: tracks the pin only through power-on or forced reset,
    // so the value at the reset release decides the operating mode
    always_ff @(posedge CLOCK) begin
        if (!RST_N && (!POR_N || FORCE_RST)) begin
            ms_low_r <= !BKGD_I; // R7
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            BACKGROUND_MODE <= 1'b0;
        end else begin
            BACKGROUND_MODE <= ms_low_r; // R9
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debug bit engine: low phase, speed-up high, release, 16 cycles total
    always_comb begin
        bdc_st_nxt = bdc_st_r;
        unique case (bdc_st_r)
            ST_IDLE: begin
                if (wr_en && ADDRESS == OFS_BDCTX && dbg_en_r) begin
                    bdc_st_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                if (cnt_r == low_len_r - 4'(1)) bdc_st_nxt = ST_SPEED;
            end
            ST_SPEED: begin
                if (cnt_r == low_len_r + 4'(SPEEDUP - 1)) bdc_st_nxt = ST_REST; // R11
            end
            ST_REST: begin
                if (cnt_r == 4'(BIT_CYCLES - 1)) bdc_st_nxt = ST_IDLE; // R10
            end
            default: bdc_st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            bdc_st_r <= ST_IDLE;
            cnt_r <= '0;
            low_len_r <= 4'(LOW_ONE);
        end else begin
            bdc_st_r <= bdc_st_nxt;
            if (bdc_st_r == ST_IDLE) begin
                cnt_r <= '0;
                low_len_r <= WRITEDATA[0] ? 4'(LOW_ONE) : 4'(LOW_ZERO);
            end else begin
                cnt_r <= cnt_r + 4'(1); // R10
            end
        end
    end

    // Debug pad: pseudo open drain with pull-up while enabled
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            BKGD_PAD <= '{o: 1'b0, oe: 1'b0, pull: 1'b1};
        end else if (dbg_en_r) begin
            BKGD_PAD.pull <= 1'b1; // R8
            BKGD_PAD.o <= (bdc_st_nxt == ST_SPEED); // R11
            BKGD_PAD.oe <= (bdc_st_nxt == ST_LOW) || (bdc_st_nxt == ST_SPEED);
        end else begin
            BKGD_PAD.pull <= 1'b0;
            BKGD_PAD.o <= pinctl_r[B_BK_OUT];
            BKGD_PAD.oe <= pinctl_r[B_BK_DIR];
        end
    end

    // Clock selection outputs
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            CLK_SEL_EXT <= 1'b0; // R15
            OSC_STOP_RUN <= 1'b0;
        end else begin
            CLK_SEL_EXT <= clkctl_r[B_EXTCLK];
            OSC_STOP_RUN <= clkctl_r[B_OSCSTOP]; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!POR_N);

    sequence busy8;
        bdc_busy [*8];
    endsequence
    sequence low_then_speed;
        (bdc_st_r == ST_LOW) ##1 (bdc_st_r == ST_SPEED);
    endsequence

    chk_rst_en_sticky: assert property (rst_pin_en_r |=> rst_pin_en_r) // R17
        else $error("reset pin enable dropped without power-on");
    chk_reset_out_pin_en_sticky: assert property (reset_out_pin_en_r |=> reset_out_pin_en_r) // R4
        else $error("reset-out enable dropped without power-on");
    chk_ext_reset_req: assert property (
        rst_pin_en_r && !RSTPIN_I |=> SYS_RST_REQ) // R2
        else $error("external reset low not requested");
    chk_rst_pullup: assert property (rst_pin_en_r |=> RSTPIN_PULL) // R3
        else $error("reset pin pull-up not on");
    chk_reset_out_pin_level: assert property (
        reset_out_pin_en_r |=> RESET_OUT_PIN_PAD.o == $past(RST_N) && RESET_OUT_PIN_PAD.oe) // R5
        else $error("reset-out pad does not mirror reset");
    chk_dbg_en_reset: assert property (!RST_N |=> dbg_en_r) // R8
        else $error("debug pin enable not set by reset");
    chk_port_reset: assert property (
        !RST_N |=> dir_r == '0 && pull_r == '0 && !CLK_SEL_EXT) // R13
        else $error("port or clock not at reset default");
    chk_bit_time: assert property (
        $rose(bdc_busy) |-> busy8 ##1 busy8 ##1 !bdc_busy) // R10
        else $error("debug bit time not sixteen cycles");
    chk_speedup_high: assert property (
        low_then_speed |-> BKGD_PAD.oe && BKGD_PAD.o) // R11
        else $error("speed-up pulse not driven high");
    // Mode pin level at the last sampling reset edge decides the mode
    chk_mode_latch: assert property (
        $rose(RST_N) && (!$past(POR_N) || $past(FORCE_RST)) |=>
        BACKGROUND_MODE == !$past(BKGD_I, 2)) // R9
        else $error("background mode not taken at release");

endmodule : reset_debug_pin_config

// [hw/pin_cfg_pkg.sv]
// Constants, register map and carrier types of the reset and debug pin block
package pin_cfg_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] OFS_SYSOPT = 6'h00;
    localparam logic [5:0] OFS_DIR = 6'h04;
    localparam logic [5:0] OFS_OUT = 6'h08;
    localparam logic [5:0] OFS_PULL = 6'h0C;
    localparam logic [5:0] OFS_DRIVE = 6'h10;
    localparam logic [5:0] OFS_SLEW = 6'h14;
    localparam logic [5:0] OFS_DATA = 6'h18;
    localparam logic [5:0] OFS_PINCTL = 6'h1C;
    localparam logic [5:0] OFS_CLKCTL = 6'h20;
    localparam logic [5:0] OFS_BDCTX = 6'h24;
    // system_options_one fields
    localparam int B_RSTPIN = 0;
    localparam int B_RSTOUT = 1;
    localparam int B_DBGEN = 2;
    // Pin control fields
    localparam int B_PC4_DIR = 0;
    localparam int B_PC4_OUT = 1;
    localparam int B_PA5_PULL = 2;
    localparam int B_BK_DIR = 3;
    localparam int B_BK_OUT = 4;
    localparam int B_PA5_LVL = 8;
    localparam int B_BK_LVL = 9;
    localparam int B_MS_LOW = 10;
    localparam int B_BUSY = 11;
    // Clock control fields
    localparam int B_EXTCLK = 0;
    localparam int B_OSCSTOP = 1;
    // Debug serial bit timing, in debug clock cycles
    localparam int BIT_CYCLES = 16;
    localparam int LOW_ONE = 4;
    localparam int LOW_ZERO = 13;
    localparam int SPEEDUP = 1;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOW = 4'b0010,
        ST_SPEED = 4'b0100,
        ST_REST = 4'b1000
    } bdc_st_e;
    // One two-way pin toward the pad
    typedef struct packed {
        logic o;
        logic oe;
        logic pull;
    } pad_s;
endpackage : pin_cfg_pkg

// [tb/debug_pod_model.sv]
// Far-side model: external reset source and background debug pod
`timescale 1ns/1ps
module debug_pod_model
    import pin_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic hold_rst_low,
    input wire logic hold_ms_low,
    input wire logic rst_pull,
    input wire pin_cfg_pkg::pad_s bk_pad,
    output logic rst_lvl,
    output logic bk_lvl,
    output logic rx_v,
    output logic rx_bit,
    output logic [7:0] rx_low
);
    logic flt_r;
    logic [7:0] low_cnt_r;
    ////////////////////////////////////////////////////////////////////////////
    // Start values, no clock edge seen yet
    initial begin
        flt_r = 1'b0;
        low_cnt_r = 8'h00;
        rx_v = 1'b0;
        rx_bit = 1'b0;
        rx_low = 8'h00;
    end
    // Undriven lines wander each cycle so a stale level never passes
    always @(posedge clk) begin
        flt_r <= ~flt_r;
    end
    // Source drives reset low; otherwise only the pin's pull-up holds it
    assign rst_lvl = hold_rst_low ? 1'b0 : (rst_pull ? 1'b1 : flt_r);
    // Pod pulls low open-drain; device drive wins, then the pull-up
    assign bk_lvl = bk_pad.oe ? bk_pad.o : (hold_ms_low ? 1'b0 : (bk_pad.pull ? 1'b1 : flt_r));
    ////////////////////////////////////////////////////////////////////////////
    // Count driven-low cycles; the speed-up pulse closes one bit
    always @(posedge clk) begin
        rx_v <= 1'b0;
        if (bk_pad.oe && !bk_pad.o) begin
            low_cnt_r <= low_cnt_r + 8'h01;
        end else if (bk_pad.oe && bk_pad.o && low_cnt_r != 8'h00) begin
            rx_v <= 1'b1;
            rx_bit <= (low_cnt_r < 8'h08);
            rx_low <= low_cnt_r;
            low_cnt_r <= 8'h00;
        end
    end
endmodule : debug_pod_model

// [tb/reset_debug_pin_config_tb_top.sv]
// Self-checking bench of the reset and debug pin block
`timescale 1ns/1ps
module reset_debug_pin_config_tb_top;
    import pin_cfg_pkg::*;
    logic CLOCK, RST_N, POR_N, FORCE_RST, READ, WRITE, WAITREQUEST;
    logic [ADDR_W-1:0] ADDRESS;
    logic [31:0] WRITEDATA, READDATA;
    logic RSTPIN_I, RSTPIN_PULL, SYS_RST_REQ, BKGD_I, BACKGROUND_MODE, CLK_SEL_EXT, OSC_STOP_RUN;
    pad_s RESET_OUT_PIN_PAD, BKGD_PAD;
    logic [7:0] PORT_I, PERIPH_SEL, PERIPH_OE, PERIPH_O, PORT_O, PORT_OE, PORT_PULL;
    logic [7:0] PORT_DRIVE, PORT_SLEW, rx_low, dir, out, pul, drv, slw, psel, poe, po, oe_x;
    logic hold_rst_low, hold_ms_low, rx_v, rx_bit;
    logic [31:0] rd_q[$], exp_q[$], got_q[$];
    int errors, cmp_count, seed;
    event note_ev;
    ////////////////////////////////////////////////////////////////////////////
    reset_debug_pin_config u_dut (.CLOCK(CLOCK), .RST_N(RST_N), .POR_N(POR_N),
        .FORCE_RST(FORCE_RST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
        .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
        .RSTPIN_I(RSTPIN_I), .RSTPIN_PULL(RSTPIN_PULL), .SYS_RST_REQ(SYS_RST_REQ),
        .RSTOPIN_I(1'b0), .RESET_OUT_PIN_PAD(RESET_OUT_PIN_PAD), .BKGD_I(BKGD_I), .BKGD_PAD(BKGD_PAD),
        .BACKGROUND_MODE(BACKGROUND_MODE), .PORT_I(PORT_I), .PERIPH_SEL(PERIPH_SEL),
        .PERIPH_OE(PERIPH_OE), .PERIPH_O(PERIPH_O), .PORT_O(PORT_O), .PORT_OE(PORT_OE),
        .PORT_PULL(PORT_PULL), .PORT_DRIVE(PORT_DRIVE), .PORT_SLEW(PORT_SLEW),
        .CLK_SEL_EXT(CLK_SEL_EXT), .OSC_STOP_RUN(OSC_STOP_RUN));
    debug_pod_model u_pod (.clk(CLOCK), .hold_rst_low(hold_rst_low),
        .hold_ms_low(hold_ms_low), .rst_pull(RSTPIN_PULL), .bk_pad(BKGD_PAD),
        .rst_lvl(RSTPIN_I), .bk_lvl(BKGD_I), .rx_v(rx_v), .rx_bit(rx_bit), .rx_low(rx_low));
    // 250 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Note a pin observation; the watcher compares it
    task chk(input logic [31:0] got, input logic [31:0] exp);
        exp_q.push_back(exp);
        got_q.push_back(got);
        -> note_ev;
    endtask : chk
    // Request held until waitrequest is sampled low; left up for back-to-back use
    task bus_go(input logic rd, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        READ <= rd;
        WRITE <= !rd;
        ADDRESS <= a;
        WRITEDATA <= d;
        do begin
            @(posedge CLOCK);
            n++;
        end while (WAITREQUEST !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
    endtask : bus_go
    task bus_rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus_go(1'b1, a, 32'h0000_0000);
    endtask : bus_rd
    task bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus_go(1'b0, a, d);
    endtask : bus_wr
    task nap(input int n);
        READ <= 1'b0;
        WRITE <= 1'b0;
        repeat (n) @(posedge CLOCK);
    endtask : nap
    task wait_rx;
        int n;
        nap(1);
        for (n = 0; n < 40 && rx_v !== 1'b1; n++) @(posedge CLOCK);
        if (n >= 40) begin
            errors++;
            give_verdict();
        end
    endtask : wait_rx
    task go_reset(input logic por, input logic frc);
        RST_N <= 1'b0;
        POR_N <= !por;
        FORCE_RST <= frc;
        repeat (2) @(posedge CLOCK);
    endtask : go_reset
    task end_reset;
        RST_N <= 1'b1;
        POR_N <= 1'b1;
        FORCE_RST <= 1'b0;
        repeat (2) @(posedge CLOCK);
    endtask : end_reset
    ////////////////////////////////////////////////////////////////////////////
    // Watchers: read data at the completing edge, pin notes as they come
    always @(posedge CLOCK) begin
        if (READ === 1'b1 && WAITREQUEST === 1'b0) cmp(READDATA, rd_q.pop_front());
    end
    initial forever begin
        @(note_ev);
        while (got_q.size() > 0) cmp(got_q.pop_front(), exp_q.pop_front());
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge CLOCK);
        errors++;
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {RST_N, POR_N, FORCE_RST, READ, WRITE, hold_rst_low, hold_ms_low} = 7'h00;
        {ADDRESS, WRITEDATA, PORT_I, PERIPH_SEL, PERIPH_OE, PERIPH_O} = '0;
        errors = 0;
        cmp_count = 0;
        seed = 30;
        repeat (2) @(posedge CLOCK);
        end_reset();
        // Power-on defaults
        chk(32'({PORT_OE, PORT_PULL, RESET_OUT_PIN_PAD.oe}), 32'h0);
        chk(32'({CLK_SEL_EXT, BACKGROUND_MODE}), 32'h0);
        chk(32'({BKGD_PAD.oe, BKGD_PAD.pull}), 32'h1);
        bus_rd(OFS_SYSOPT, 32'h4);
        bus_wr(6'h3C, 32'hFFFF_FFFF);
        bus_rd(6'h3C, 32'h0);
        // Both debug bit values, busy over one bit time
        for (int b = 1; b >= 0; b--) begin
            bus_wr(OFS_BDCTX, 32'(b));
            bus_rd(OFS_BDCTX, 32'h1);
            wait_rx();
            chk(32'(rx_bit), 32'(b));
            chk(32'(rx_low), b ? 32'(LOW_ONE) : 32'(LOW_ZERO));
            nap(16);
            bus_rd(OFS_BDCTX, 32'h0);
        end
        // Random port settings with peripheral ownership mixed in
        for (int i = 0; i < 4; i++) begin
            {dir, out, pul, drv} = $random(seed);
            {slw, psel, poe, po} = $random(seed);
            bus_wr(OFS_DIR, 32'(dir));
            bus_wr(OFS_OUT, 32'(out));
            bus_wr(OFS_PULL, 32'(pul));
            bus_wr(OFS_DRIVE, 32'(drv));
            bus_wr(OFS_SLEW, 32'(slw));
            PORT_I <= pul ^ drv;
            {PERIPH_SEL, PERIPH_OE, PERIPH_O} <= {psel, poe, po};
            nap(2);
            oe_x = (psel & poe) | (~psel & dir);
            chk(32'(PORT_OE), 32'(oe_x));
            chk(32'(PORT_O), 32'((psel & po) | (~psel & out)));
            chk(32'(PORT_PULL), 32'(pul & ~oe_x));
            chk(32'({PORT_DRIVE, PORT_SLEW}), 32'({drv, slw}));
            bus_rd(OFS_DATA, 32'((dir & out) | (~dir & (pul ^ drv))));
        end
        // Reset pin ignored until enabled, then pulled up and honoured
        hold_rst_low <= 1'b1;
        nap(2);
        chk(32'(SYS_RST_REQ), 32'h0);
        bus_wr(OFS_SYSOPT, 32'h5);
        nap(2);
        chk(32'({RSTPIN_PULL, SYS_RST_REQ}), 32'h3);
        hold_rst_low <= 1'b0;
        nap(2);
        chk(32'({RSTPIN_PULL, SYS_RST_REQ}), 32'h2);
        // Zero to bit 0 is ignored, debug enable cleared, reset-out selected
        bus_wr(OFS_SYSOPT, 32'h2);
        bus_rd(OFS_SYSOPT, 32'h3);
        // Debug enable clear: bit send refused, pin on its port controls
        bus_wr(OFS_BDCTX, 32'h1);
        bus_rd(OFS_BDCTX, 32'h0);
        bus_wr(OFS_PINCTL, 32'h18);
        nap(2);
        chk(32'(BKGD_PAD), 32'h6);
        bus_rd(OFS_PINCTL, 32'h318);
        bus_wr(OFS_CLKCTL, 32'h3);
        bus_rd(OFS_CLKCTL, 32'h3);
        nap(2);
        chk(32'(RESET_OUT_PIN_PAD), 32'h6);
        chk(32'({CLK_SEL_EXT, OSC_STOP_RUN}), 32'h3);
        go_reset(1'b0, 1'b0);
        chk(32'(RESET_OUT_PIN_PAD), 32'h2);
        end_reset();
        chk(32'(RESET_OUT_PIN_PAD), 32'h6);
        chk(32'(CLK_SEL_EXT), 32'h0);
        bus_rd(OFS_SYSOPT, 32'h7);
        // Forced reset with mode pin low, then power-on with it high
        nap(1);
        hold_ms_low <= 1'b1;
        go_reset(1'b0, 1'b1);
        end_reset();
        hold_ms_low <= 1'b0;
        chk(32'(BACKGROUND_MODE), 32'h1);
        go_reset(1'b1, 1'b0);
        end_reset();
        chk(32'({BACKGROUND_MODE, RESET_OUT_PIN_PAD.oe}), 32'h0);
        bus_rd(OFS_SYSOPT, 32'h4);
        // Port controls of the two dedicated pins after power-on
        bus_wr(OFS_PINCTL, 32'h7);
        nap(2);
        chk(32'({RSTPIN_PULL, RESET_OUT_PIN_PAD}), 32'hE);
        nap(2);
        give_verdict();
    end
endmodule : reset_debug_pin_config_tb_top
